// File: verilog/fbr_rate_gen.sv
// fractional baud rate generator: prescaler, tx and rx divisor chains
`timescale 1ns/1ns
`default_nettype none
`include "fbr_params.svh"

module fbr_rate_gen
  import fbr_pkg::*;
#(
  parameter int PRESCALE_DIV = 4
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // register port from the serial host interface
  input wire fbr_req_t reg_req,
  output logic [7:0] reg_rdata,
  // sampling and bit strobes
  output fbr_rate_t tx_rate,
  output fbr_rate_t rx_rate
);

  // prescaler counter is eight bits wide
  if (PRESCALE_DIV < 2 || PRESCALE_DIV > 256) begin : g_chk
    $error("PRESCALE_DIV must lie in 2..256");
  end

  localparam logic [7:0] PRE_LAST = 8'(PRESCALE_DIV - 1);

  // whole block state
  typedef struct packed {
    fbr_gen_t [1:0] gen;
    logic [7:0] modem_ctrl;
    logic [7:0] pre_cnt;
    logic [7:0] rdata;
  } fbr_state_t;

  fbr_state_t st;
  fbr_state_t next_st;
  logic pre_tick; // one prescaled oscillator period
  logic pre4; // prescaler select bit

  // prescaler: every clock, or every PRESCALE_DIV clocks
  assign pre4 = st.modem_ctrl[`FBR_MCR_PRESCALE_BIT];
  assign pre_tick = pre4 ? (st.pre_cnt == PRE_LAST) : 1'b1;

  // samples per bit for a mode field; the reserved code falls back to 16x
  function automatic logic [4:0] ratio_of(input logic [1:0] m);
    logic [4:0] r;
    r = `FBR_RATIO_16X;
    case (fbr_mode_t'(m))
      FBR_MODE_8X: r = `FBR_RATIO_8X;
      FBR_MODE_4X: r = `FBR_RATIO_4X;
      default: r = `FBR_RATIO_16X;
    endcase
    return r;
  endfunction

  // next state for registers, prescaler and both generators
  always_comb begin
    logic [15:0] div;
    logic [4:0] sum;
    logic [4:0] ratio;
    logic sel_rx;
    int i;
    div = 16'h0000;
    i = 0;
    sum = 5'h00;
    ratio = 5'h00;
    sel_rx = reg_req.addr[`FBR_ADDR_RX_BIT];
    next_st = st;
    // prescaler count only runs in divide by four mode
    if (!pre4 || pre_tick) begin
      next_st.pre_cnt = 8'h00;
    end else begin
      next_st.pre_cnt = st.pre_cnt + 8'h01;
    end
    // one generator per direction, each on its own divisor set
    for (i = 0; i < 2; i++) begin
      next_st.gen[i].tick = 1'b0;
      next_st.gen[i].bit_tick = 1'b0;
      // a zero integer is served as one, the documented floor
      div = {st.gen[i].div_high, st.gen[i].div_low};
      if (div == 16'h0000) begin
        div = 16'h0001;
      end
      // fraction accumulator carry decides the stretched periods
      sum = {1'b0, st.gen[i].acc} +
            {1'b0, st.gen[i].div_frac[`FBR_FRAC_MSB:`FBR_FRAC_LSB]};
      ratio = ratio_of(st.gen[i].div_frac[`FBR_MODE_MSB:`FBR_MODE_LSB]);
      if (pre_tick) begin
        if (st.gen[i].cnt == 16'h0000) begin
          // period over: emit a sample strobe and reload
          next_st.gen[i].tick = 1'b1;
          next_st.gen[i].acc = sum[3:0];
          next_st.gen[i].stretch = sum[4];
          // stretched period is one prescaled tick longer
          next_st.gen[i].cnt = (div - 16'h0001) + {15'h0000, sum[4]};
          // bit boundary after ratio samples; odd 8x fractions jitter
          if (st.gen[i].smp >= ratio - 5'h01) begin
            next_st.gen[i].smp = 5'h00;
            next_st.gen[i].bit_tick = 1'b1;
          end else begin
            next_st.gen[i].smp = st.gen[i].smp + 5'h01;
          end
        end else begin
          next_st.gen[i].cnt = st.gen[i].cnt - 16'h0001;
        end
      end
    end
    // register writes; new divisors take hold at the next reload
    if (reg_req.wr) begin
      case ({1'b0, reg_req.addr[2:0]})
        `FBR_ADDR_DIV_LOW: next_st.gen[sel_rx].div_low = reg_req.wdata;
        `FBR_ADDR_DIV_HIGH:
          next_st.gen[sel_rx].div_high = reg_req.wdata;
        `FBR_ADDR_DIV_FRAC:
          next_st.gen[sel_rx].div_frac = reg_req.wdata;
        `FBR_ADDR_MODEM_CTRL: next_st.modem_ctrl = reg_req.wdata;
        default: next_st.modem_ctrl = st.modem_ctrl; // unmapped: ignored
      endcase
    end
    // register reads answer on the next cycle
    if (reg_req.rd) begin
      case ({1'b0, reg_req.addr[2:0]})
        `FBR_ADDR_DIV_LOW: next_st.rdata = st.gen[sel_rx].div_low;
        `FBR_ADDR_DIV_HIGH: next_st.rdata = st.gen[sel_rx].div_high;
        `FBR_ADDR_DIV_FRAC: next_st.rdata = st.gen[sel_rx].div_frac;
        `FBR_ADDR_MODEM_CTRL: next_st.rdata = st.modem_ctrl;
        default: next_st.rdata = 8'h00; // unmapped reads zero
      endcase
    end
  end

  // state register; reset loads the divisor of one in both sets
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
      st.gen[0].div_low <= `FBR_RST_DIV_LOW;
      st.gen[0].div_high <= `FBR_RST_DIV_HIGH;
      st.gen[0].div_frac <= `FBR_RST_DIV_FRAC;
      st.gen[1].div_low <= `FBR_RST_DIV_LOW;
      st.gen[1].div_high <= `FBR_RST_DIV_HIGH;
      st.gen[1].div_frac <= `FBR_RST_DIV_FRAC;
      st.modem_ctrl <= `FBR_RST_MODEM_CTRL;
    end else begin
      next_st_apply: st <= next_st;
    end
  end

  // outputs straight from flip-flops
  assign reg_rdata = st.rdata;
  assign tx_rate = '{sample: st.gen[0].tick,
                     bit_adv: st.gen[0].bit_tick};
  assign rx_rate = '{sample: st.gen[1].tick,
                     bit_adv: st.gen[1].bit_tick};

  // checks on the generated strobes, the counters and the register port
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  property p_pre_div1;
    !pre4 |-> pre_tick;
  endproperty
  a_pre_div1: assert property (p_pre_div1)
    else $error("prescaler stalls in divide by one");

  property p_pre_div4;
    (pre4 && pre_tick && !reg_req.wr) |=> !pre_tick;
  endproperty
  a_pre_div4: assert property (p_pre_div4)
    else $error("prescaler ticks back to back in divide by four");

  property p_tick_on_reload;
    (pre_tick && st.gen[0].cnt == 16'h0000) |=> st.gen[0].tick;
  endproperty
  a_tick_on_reload: assert property (p_tick_on_reload)
    else $error("tx sample strobe missing at reload");

  property p_no_stretch;
    (pre_tick && st.gen[1].cnt == 16'h0000 &&
     st.gen[1].div_frac[3:0] == 4'h0) |=> !st.gen[1].stretch;
  endproperty
  a_no_stretch: assert property (p_no_stretch)
    else $error("stretch with zero fraction");

  property p_bit_on_sample;
    st.gen[0].bit_tick |-> st.gen[0].tick;
  endproperty
  a_bit_on_sample: assert property (p_bit_on_sample)
    else $error("bit strobe without sample strobe");

  property p_mode4x;
    (pre_tick && st.gen[1].cnt == 16'h0000 && st.gen[1].smp == 5'h03 &&
     st.gen[1].div_frac[5:4] == 2'h2) |=> st.gen[1].bit_tick;
  endproperty
  a_mode4x: assert property (p_mode4x)
    else $error("4x mode bit strobe missing after four samples");

  property p_indep;
    (reg_req.wr && !reg_req.addr[3]) |=>
      $stable(st.gen[1].div_low) && $stable(st.gen[1].div_frac);
  endproperty
  a_indep: assert property (p_indep)
    else $error("tx write disturbed rx divisor");

  property p_read_low;
    (reg_req.rd && reg_req.addr == `FBR_ADDR_DIV_LOW) |=>
      reg_rdata == $past(st.gen[0].div_low);
  endproperty
  a_read_low: assert property (p_read_low)
    else $error("low divisor byte read back wrong");

  // a new divisor only lands at a reload, so the counter must be idle
  property p_div_one;
    (st.gen[0].div_low == 8'h01 && st.gen[0].div_high == 8'h00 &&
     st.gen[0].div_frac == 8'h00 && !pre4 && !reg_req.wr &&
     st.gen[0].cnt == 16'h0000) |=>
      st.gen[0].cnt == 16'h0000;
  endproperty
  a_div_one: assert property (p_div_one)
    else $error("divisor of one does not tick every cycle");

  property p_rx_tick_on_reload;
    (pre_tick && st.gen[1].cnt == 16'h0000) |=> st.gen[1].tick;
  endproperty
  a_rx_tick_on_reload: assert property (p_rx_tick_on_reload)
    else $error("rx sample strobe missing at reload");

  property p_count_down;
    (pre_tick && st.gen[0].cnt != 16'h0000) |=>
      st.gen[0].cnt == $past(st.gen[0].cnt) - 16'h0001;
  endproperty
  a_count_down: assert property (p_count_down)
    else $error("tx period counter skipped a step");

  // between prescaled ticks no generator may move
  property p_hold;
    !pre_tick |=> $stable(st.gen[0].cnt) && $stable(st.gen[1].cnt);
  endproperty
  a_hold: assert property (p_hold)
    else $error("generator counted without a prescaled tick");

  property p_stretch_len;
    (pre_tick && st.gen[0].cnt == 16'h0000 &&
     {st.gen[0].div_high, st.gen[0].div_low} <= 16'h0001) |=>
      st.gen[0].cnt == {15'h0000, st.gen[0].stretch};
  endproperty
  a_stretch_len: assert property (p_stretch_len)
    else $error("stretched period not one tick longer");

  // a fraction of fifteen carries on every reload but the one after zero
  property p_frac_max;
    (pre_tick && st.gen[1].cnt == 16'h0000 && st.gen[1].acc != 4'h0 &&
     st.gen[1].div_frac[3:0] == 4'hf) |=> st.gen[1].stretch;
  endproperty
  a_frac_max: assert property (p_frac_max)
    else $error("fraction of fifteen did not stretch");

  property p_rx_bit_on_sample;
    st.gen[1].bit_tick |-> st.gen[1].tick;
  endproperty
  a_rx_bit_on_sample: assert property (p_rx_bit_on_sample)
    else $error("rx bit strobe without sample strobe");

  property p_mode8x;
    (pre_tick && st.gen[0].cnt == 16'h0000 && st.gen[0].smp == 5'h07 &&
     st.gen[0].div_frac[5:4] == 2'h1) |=> st.gen[0].bit_tick;
  endproperty
  a_mode8x: assert property (p_mode8x)
    else $error("8x mode bit strobe missing after eight samples");

  property p_mode16x_hold;
    (pre_tick && st.gen[0].cnt == 16'h0000 && st.gen[0].smp == 5'h07 &&
     st.gen[0].div_frac[5:4] == 2'h0) |=> !st.gen[0].bit_tick;
  endproperty
  a_mode16x_hold: assert property (p_mode16x_hold)
    else $error("16x mode bit strobe after eight samples");

  property p_rdata_hold;
    !reg_req.rd |=> $stable(reg_rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data changed without a read");

  property p_modem_write;
    (reg_req.wr && reg_req.addr[2:0] == 3'h3) |=>
      st.modem_ctrl == $past(reg_req.wdata);
  endproperty
  a_modem_write: assert property (p_modem_write)
    else $error("modem control write did not land");

  property p_rx_write;
    (reg_req.wr && reg_req.addr == 4'h8) |=>
      st.gen[1].div_low == $past(reg_req.wdata) &&
      $stable(st.gen[0].div_low);
  endproperty
  a_rx_write: assert property (p_rx_write)
    else $error("rx low divisor write missed or hit tx");

endmodule

`default_nettype wire

// File: verilog/fbr_params.svh
// constants for the fractional rate generator: addresses, fields, resets
`ifndef FBR_PARAMS_SVH
`define FBR_PARAMS_SVH

// register addresses on the block's register port (bit 3 picks rx set)
`define FBR_ADDR_DIV_LOW 4'h0
`define FBR_ADDR_DIV_HIGH 4'h1
`define FBR_ADDR_DIV_FRAC 4'h2
`define FBR_ADDR_MODEM_CTRL 4'h3
`define FBR_ADDR_RX_BIT 3

// field positions
`define FBR_MCR_PRESCALE_BIT 7
`define FBR_FRAC_LSB 0
`define FBR_FRAC_MSB 3
`define FBR_MODE_LSB 4
`define FBR_MODE_MSB 5

// reset values of the divisor set and the control register
`define FBR_RST_DIV_LOW 8'h01
`define FBR_RST_DIV_HIGH 8'h00
`define FBR_RST_DIV_FRAC 8'h00
`define FBR_RST_MODEM_CTRL 8'h00

// sampling clocks per bit for each mode
`define FBR_RATIO_16X 5'h10
`define FBR_RATIO_8X 5'h08
`define FBR_RATIO_4X 5'h04

`endif

// File: verilog/fbr_pkg.sv
// types shared by the fractional rate generator
`default_nettype none

package fbr_pkg;

  // oversampling mode field encoding
  typedef enum logic [1:0] {
    FBR_MODE_16X = 2'h0,
    FBR_MODE_8X = 2'h1,
    FBR_MODE_4X = 2'h2,
    FBR_MODE_RSVD = 2'h3
  } fbr_mode_t;

  // one rate generator: its divisor set and its counters
  typedef struct packed {
    logic [7:0] div_low;
    logic [7:0] div_high;
    logic [7:0] div_frac;
    logic [15:0] cnt;
    logic [3:0] acc;
    logic stretch;
    logic [4:0] smp;
    logic tick;
    logic bit_tick;
  } fbr_gen_t;

  // register access request from the serial host interface
  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } fbr_req_t;

  // sampling and bit strobes of one direction
  typedef struct packed {
    logic sample;
    logic bit_adv;
  } fbr_rate_t;

endpackage

`default_nettype wire

// File: testbench/tb_fbr_rate_gen.sv
// self-checking bench for the fractional rate generator
`timescale 1ns/1ns
`default_nettype none

module tb_fbr_rate_gen;
  import fbr_pkg::*;

  localparam int PRE = 4; // prescale ratio handed to the design
  logic clk_sys = 1'b0; // 125 MHz system clock
  logic rst_n = 1'b0; // asynchronous reset, active low
  fbr_req_t req = '0; // register requests from the bench
  logic [7:0] reg_rdata; // read data, one cycle after the read
  fbr_rate_t tx_rate; // transmit strobes
  fbr_rate_t rx_rate; // receive strobes
  logic [7:0] exp_q[$]; // expected read data, oldest first
  logic rd_pend = 1'b0; // a read was taken at the last edge
  int err_total = 0; // mismatches seen
  int compares = 0; // comparisons made

  // half period of 4 ns
  always #4 clk_sys = ~clk_sys;

  fbr_rate_gen #(.PRESCALE_DIV(PRE)) u_fbr_rate_gen (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .reg_req(req),
    .reg_rdata(reg_rdata),
    .tx_rate(tx_rate),
    .rx_rate(rx_rate)
  );

  // compare one value and report a mismatch at once
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // single exit point, also used when a wait runs out
  task automatic tally_and_finish();
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // one-cycle write pulse, launched off the falling edge
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge clk_sys);
    req <= '0;
  endtask

  // one-cycle read pulse; the watcher judges the answer
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    @(negedge clk_sys);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge clk_sys);
    req <= '0;
  endtask

  // watcher: read data is settled by the falling edge after the take
  always @(posedge clk_sys) rd_pend <= req.rd;
  always @(negedge clk_sys) begin
    if (rd_pend && exp_q.size() > 0) begin
      check(reg_rdata, exp_q.pop_front());
    end
  end

  // time sixteen sample periods of one direction; two pulses are
  // skipped first because a new divisor only lands at the next reload
  task automatic measure(input int rx, input int ep, input int eb,
                         input int es);
    int t, per, n, cyc, bits, lo, hi;
    logic smp;
    t = 0; per = 0; n = 0; cyc = 0; bits = 0; lo = 1 << 30; hi = 0;
    while (n < 18 && t < 40000) begin
      @(negedge clk_sys);
      t++;
      per++;
      smp = rx ? rx_rate.sample : tx_rate.sample;
      if (smp === 1'b1) begin
        n++;
        if (n > 2) begin
          cyc += per;
          lo = (per < lo) ? per : lo;
          hi = (per > hi) ? per : hi;
          bits += ((rx ? rx_rate.bit_adv : tx_rate.bit_adv) === 1'b1);
        end
        per = 0;
      end
    end
    if (n < 18) begin
      err_total++;
      tally_and_finish();
    end else begin
      check(cyc, ep);
      check(bits, eb);
      check(hi - lo, es);
    end
  endtask

  // main sequence
  initial begin
    int k, s, p, ev;
    int d[2];
    int f[2];
    int m[2];
    void'($urandom(32'ha871));
    repeat (3) @(negedge clk_sys);
    rst_n = 1'b1;
    // reset values of both sets, unmapped places read zero
    for (k = 0; k < 16; k++) begin
      rd(4'(k), (k % 8 == 0) ? 8'h01 : 8'h00);
    end
    // unmapped write is ignored
    wr(4'h5, 8'hff);
    rd(4'h5, 8'h00);
    // read back random values in every divisor register of both sets
    for (k = 0; k < 6; k++) begin
      ev = $urandom_range(255, 0);
      wr(4'((k / 3) * 8 + k % 3), 8'(ev));
      rd(4'((k / 3) * 8 + k % 3), 8'(ev));
    end
    // rate cases: tx and rx modes differ in the first four; integer 0 counts as 1
    for (k = 0; k < 20; k++) begin
      p = (k < 2) ? 1 : ($urandom_range(1, 0) ? PRE : 1);
      wr(4'h3, (p == 1) ? 8'h00 : 8'h80);
      rd(4'h3, (p == 1) ? 8'h00 : 8'h80);
      for (s = 0; s < 2; s++) begin
        d[s] = (k == 0) ? 0 : (k == 1) ? 256 : $urandom_range(40, 1);
        f[s] = (k == 0) ? 15 : $urandom_range(15, 0);
        m[s] = (k < 4) ? k : $urandom_range(3, 0);
        if (s == 1 && k < 4) m[s] = 3 - k;
        wr(4'(s * 8), 8'(d[s]));
        wr(4'(s * 8 + 1), 8'(d[s] >> 8));
        wr(4'(s * 8 + 2), {2'b00, 2'(m[s]), 4'(f[s])});
      end
      for (s = 0; s < 2; s++) begin
        ev = (16 * ((d[s] == 0) ? 1 : d[s]) + f[s]) * p;
        measure(s, ev, (m[s] == 1) ? 2 : (m[s] == 2) ? 4 : 1,
                (f[s] != 0) ? p : 0);
      end
    end
    // mid-run reset must bring back the defaults of both sets
    @(negedge clk_sys);
    rst_n = 1'b0;
    repeat (2) @(negedge clk_sys);
    rst_n = 1'b1;
    for (k = 0; k < 16; k++) begin
      rd(4'(k), (k % 8 == 0) ? 8'h01 : 8'h00);
    end
    // let the watcher judge the last read before the verdict
    repeat (2) @(negedge clk_sys);
    tally_and_finish();
  end
endmodule

`default_nettype wire
